// file: hw/atc_pkg.sv
package atc_pkg;

    // register byte offsets
    localparam logic [7:0] ATC_CSR_OFS = 8'h00;
    localparam logic [7:0] ATC_CR_OFS = 8'h04;
    localparam logic [7:0] ATC_MSTOP_OFS = 8'h08;
    localparam logic [7:0] ATC_IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] ATC_IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] ATC_DATA_OFS = 8'h20;

    // control/status field positions
    localparam int ATC_CSR_FLAG = 7;
    localparam int ATC_CSR_IE = 6;
    localparam int ATC_CSR_START = 5;
    localparam int ATC_CSR_SCAN = 4;
    localparam int ATC_CR_TRGS_LO = 6;
    localparam int ATC_CR_CKS_LO = 2;

    // values after reset and fixed encodings
    localparam logic [3:0] ATC_CH_RST = 4'h0;
    localparam logic [1:0] ATC_TRGS_RST = 2'h0;
    localparam logic [1:0] ATC_CKS_RST = 2'h0;
    localparam logic ATC_MSTOP_RST = 1'b1;
    localparam logic [1:0] ATC_TRGS_EXT = 2'h3;
    localparam logic [1:0] ATC_CR_RSVD = 2'h3;

    // conversion length in states (one state is one clk cycle)
    localparam logic [9:0] ATC_SINGLE_CYC0 = 10'd530;
    localparam logic [9:0] ATC_SINGLE_CYC1 = 10'd266;
    localparam logic [9:0] ATC_SINGLE_CYC2 = 10'd134;
    localparam logic [9:0] ATC_SINGLE_CYC3 = 10'd68;
    localparam logic [9:0] ATC_SCAN_CYC0 = 10'd512;
    localparam logic [9:0] ATC_SCAN_CYC1 = 10'd256;
    localparam logic [9:0] ATC_SCAN_CYC2 = 10'd128;
    localparam logic [9:0] ATC_SCAN_CYC3 = 10'd64;

    typedef enum logic [1:0] {
        ATC_IDLE = 2'b01,
        ATC_CONV = 2'b10
    } atc_state_t;

endpackage

// file: hw/atc_trig_sync.sv
`timescale 1ns/1ps
module atc_trig_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trig_n,
    output logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // pin idles high, so the chain resets high to avoid a false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= trig_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // edge taken from the settled stages only
    assign fall = s3_q & ~s2_q;

    a_trig_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        fall |=> !fall) else $error("trigger pulse longer than one cycle");
endmodule

// file: hw/atc_conv_timer.sv
`timescale 1ns/1ps
module atc_conv_timer #(
    parameter int W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic abort,
    input wire logic [W-1:0] load,
    output logic done
);
    logic [W-1:0] cnt_q;

    // down counter; done marks the last state of the conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (abort) begin
            cnt_q <= '0;
        end else if (go) begin
            cnt_q <= load;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == W'(1));
endmodule

// file: hw/atc_adc_ctrl.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module atc_adc_ctrl
    import atc_pkg::*;
#(
    parameter int NDATA = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_convert_trigger_n,
    output logic conv_sample,
    output logic [3:0] conv_channel,
    input wire logic [9:0] conv_result,
    output logic conversion_end_irq,
    output logic xfer_req
);
    atc_state_t state_q;
    logic stop_q;
    logic start_q;
    logic start_d;
    logic flag_q;
    logic ie_q;
    logic scan_q;
    logic [3:0] ch_q;
    logic [1:0] trgs_q;
    logic [1:0] cks_q;
    logic [3:0] cur_ch_q;
    logic [9:0] data_q [NDATA];
    logic [31:0] prdata_q;
    logic sample_q;
    logic xfer_q;
    logic acc;
    logic wr_ok;
    logic blocked;
    logic trig_fall;
    logic trig_fire;
    logic launch;
    logic relaunch;
    logic done;
    logic conv_end;
    logic flag_set;
    logic flag_clr;
    logic hw_clr;
    logic [9:0] tmr_load;
    logic [31:0] rd_val;

    // offset decode shared by read mux and error answer
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ATC_CSR_OFS) || (a == ATC_CR_OFS) || (a == ATC_MSTOP_OFS) ||
                    (a == ATC_IRQ_STAT_OFS) || (a == ATC_IRQ_MASK_OFS) ||
                    (a[7:4] == ATC_DATA_OFS[7:4] && a[1:0] == 2'h0 && int'(a[3:2]) < NDATA);
    endfunction

    // conversion length: first conversion after start uses the single table
    function automatic logic [9:0] conv_cycles(input logic [1:0] cks, input logic repeat_conv);
        unique case (cks)
            2'h0: conv_cycles = repeat_conv ? ATC_SCAN_CYC0 : ATC_SINGLE_CYC0;
            2'h1: conv_cycles = repeat_conv ? ATC_SCAN_CYC1 : ATC_SINGLE_CYC1;
            2'h2: conv_cycles = repeat_conv ? ATC_SCAN_CYC2 : ATC_SINGLE_CYC2;
            2'h3: conv_cycles = repeat_conv ? ATC_SCAN_CYC3 : ATC_SINGLE_CYC3;
        endcase
    endfunction

    // apb: zero wait states, errors on unmapped or stopped access
    assign acc = psel & penable;
    assign blocked = stop_q && (paddr != ATC_MSTOP_OFS);
    assign wr_ok = acc & pwrite & ~blocked & is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = acc & (~is_mapped(paddr) | blocked);
    assign prdata = prdata_q;

    // trigger pin conditioning
    atc_trig_sync u_trig (
        .clk(clk),
        .rst_n(rst_n),
        .trig_n(ext_convert_trigger_n),
        .fall(trig_fall)
    );

    // pin only counts with source select at 11 and module running
    assign trig_fire = trig_fall && (trgs_q == ATC_TRGS_EXT) && !stop_q;

    // module stop register, stopped out of reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= ATC_MSTOP_RST;
        end else if (acc && pwrite && paddr == ATC_MSTOP_OFS) begin
            stop_q <= pwdata[0];
        end
    end

    // mode and channel fields; changing them mid-conversion is the user's hazard
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_q <= 1'b0;
            ch_q <= ATC_CH_RST;
        end else if (wr_ok && paddr == ATC_CSR_OFS) begin
            scan_q <= pwdata[ATC_CSR_SCAN];
            ch_q <= pwdata[3:0];
        end
    end

    // interrupt enable, reachable from the control word and the mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_q <= 1'b0;
        end else if (wr_ok && paddr == ATC_CSR_OFS) begin
            ie_q <= pwdata[ATC_CSR_IE];
        end else if (wr_ok && paddr == ATC_IRQ_MASK_OFS) begin
            ie_q <= pwdata[0];
        end
    end

    // trigger source and clock select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trgs_q <= ATC_TRGS_RST;
            cks_q <= ATC_CKS_RST;
        end else if (wr_ok && paddr == ATC_CR_OFS) begin
            trgs_q <= pwdata[ATC_CR_TRGS_LO +: 2];
            cks_q <= pwdata[ATC_CR_CKS_LO +: 2];
        end
    end

    // start bit: trigger and software share it, so all later behaviour is common
    always_comb begin
        start_d = start_q;
        if (hw_clr) begin
            start_d = 1'b0;
        end
        if (wr_ok && paddr == ATC_CSR_OFS) begin
            start_d = pwdata[ATC_CSR_START];
        end
        if (trig_fire) begin
            start_d = 1'b1;
        end
        if (stop_q) begin
            start_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    // sequencer hooks; a cleared start bit aborts and drops the result
    assign launch = (state_q == ATC_IDLE) && start_q && !stop_q;
    assign conv_end = (state_q == ATC_CONV) && start_q && done;
    assign relaunch = conv_end && scan_q;
    assign hw_clr = conv_end && !scan_q;
    assign tmr_load = conv_cycles(cks_q, relaunch);

    atc_conv_timer #(
        .W(10)
    ) u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .go(launch | relaunch),
        .abort((state_q == ATC_CONV) && !start_q),
        .load(tmr_load),
        .done(done)
    );

    // conversion state and channel walk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ATC_IDLE;
            cur_ch_q <= ATC_CH_RST;
        end else begin
            unique case (state_q)
                ATC_IDLE: begin
                    if (launch) begin
                        state_q <= ATC_CONV;
                        cur_ch_q <= scan_q ? {ch_q[3:2], 2'h0} : ch_q;
                    end
                end
                ATC_CONV: begin
                    if (!start_q) begin
                        state_q <= ATC_IDLE;
                    end else if (conv_end && !scan_q) begin
                        state_q <= ATC_IDLE;
                    end else if (relaunch) begin
                        // group wraps to its first channel and keeps going
                        cur_ch_q <= (cur_ch_q == ch_q) ? {ch_q[3:2], 2'h0} : cur_ch_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ATC_IDLE;
                end
            endcase
        end
    end

    // results land in the data register for the channel's lane
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NDATA; i++) begin
                data_q[i] <= 10'h000;
            end
        end else if (conv_end) begin
            data_q[cur_ch_q[1:0]] <= conv_result;
        end
    end

    // analog side strobe, aligned with the channel update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= launch | relaunch;
        end
    end

    assign conv_sample = sample_q;
    assign conv_channel = cur_ch_q;

    // end flag: single end, or scan group end; set wins over a clearing write
    assign flag_set = conv_end && (!scan_q || cur_ch_q == ch_q);
    assign flag_clr = (wr_ok && paddr == ATC_CSR_OFS && pwdata[ATC_CSR_FLAG]) ||
                      (wr_ok && paddr == ATC_IRQ_STAT_OFS && pwdata[0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_set | (flag_q & ~flag_clr);
        end
    end

    // level request held until software clears the flag or the enable
    assign conversion_end_irq = flag_q & ie_q;

    // one pulse per enabled end event starts a transfer controller read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_q <= 1'b0;
        end else begin
            xfer_q <= flag_set & ie_q;
        end
    end

    assign xfer_req = xfer_q;

    // read mux; stopped module reads zero except the module stop register
    always_comb begin
        rd_val = 32'h0000_0000;
        if (!blocked) begin
            if (paddr == ATC_CSR_OFS) begin
                rd_val[7:0] = {flag_q, ie_q, start_q, scan_q, ch_q};
            end else if (paddr == ATC_CR_OFS) begin
                rd_val[7:0] = {trgs_q, 2'h0, cks_q, ATC_CR_RSVD};
            end else if (paddr == ATC_MSTOP_OFS) begin
                rd_val[0] = stop_q;
            end else if (paddr == ATC_IRQ_STAT_OFS) begin
                rd_val[0] = flag_q;
            end else if (paddr == ATC_IRQ_MASK_OFS) begin
                rd_val[0] = ie_q;
            end else if (is_mapped(paddr)) begin
                rd_val[9:0] = data_q[paddr[3:2]];
            end
        end
    end

    // read data captured in the setup phase so it comes from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rd_val;
        end
    end

    a_trig_gate: assert property (@(posedge clk) disable iff (!rst_n)
        trig_fall && trgs_q != ATC_TRGS_EXT && !(wr_ok && paddr == ATC_CSR_OFS) && !start_q
        |=> !start_q) else $error("trigger started conversion while not selected");

    a_trig_start: assert property (@(posedge clk) disable iff (!rst_n)
        trig_fall && trgs_q == ATC_TRGS_EXT && !stop_q
        |=> start_q ##1 state_q == ATC_CONV) else $error("trigger did not start conversion");

    a_trig_same: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(start_q) && state_q == ATC_IDLE |=> sample_q && cur_ch_q == (scan_q ? {ch_q[3:2], 2'h0} : ch_q))
        else $error("start did not launch like a software start");

    a_flag_on_end: assert property (@(posedge clk) disable iff (!rst_n)
        conv_end && !scan_q |=> flag_q) else $error("end flag not set after conversion");

    a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
        flag_set && ie_q && !(wr_ok && (paddr == ATC_CSR_OFS || paddr == ATC_IRQ_MASK_OFS))
        |=> conversion_end_irq && xfer_req) else $error("request missing after end");

    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
        !ie_q |-> !conversion_end_irq) else $error("request with enable clear");

    a_irq_holds: assert property (@(posedge clk) disable iff (!rst_n)
        conversion_end_irq && !flag_clr && !wr_ok |=> conversion_end_irq)
        else $error("request dropped while flag set");

    a_xfer_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_req |-> conversion_end_irq ##1 !xfer_req) else $error("transfer request malformed");

    a_single_end: assert property (@(posedge clk) disable iff (!rst_n)
        conv_end && !scan_q && !trig_fire |=> !start_q && state_q == ATC_IDLE)
        else $error("single mode did not stop");

    a_single_busy: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ATC_CONV && !scan_q && !done && !(wr_ok && paddr == ATC_CSR_OFS) && !stop_q && start_q
        |=> start_q) else $error("start bit dropped mid conversion");

    a_scan_repeat: assert property (@(posedge clk) disable iff (!rst_n)
        relaunch && start_d |=> state_q == ATC_CONV ##1 !sample_q) else $error("scan did not repeat");

    a_stop_halts: assert property (@(posedge clk) disable iff (!rst_n)
        stop_q |=> !start_q && !sample_q) else $error("conversion while stopped");

    a_stop_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        acc && pwrite && stop_q && paddr == ATC_CR_OFS |=> $stable(trgs_q) && $stable(cks_q))
        else $error("write took effect while stopped");

    a_result_range: assert property (@(posedge clk) disable iff (!rst_n)
        acc && !pwrite && paddr[7:4] == ATC_DATA_OFS[7:4] |-> prdata[31:10] == 22'h0)
        else $error("result wider than ten bits");
endmodule

// file: dv/atc_far_model.sv
`timescale 1ns/1ps
module atc_far_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic conv_sample,
    input wire logic [3:0] conv_channel,
    input wire logic xfer_req,
    output logic [9:0] conv_result,
    output logic ext_convert_trigger_n,
    output int xfer_cnt,
    output int samp_cnt,
    output int conv_len
);
    int low_q;
    int cyc_q;

    // analog source: boundary codes on ch0 and ch1, held while the channel is selected
    always_comb begin
        case (conv_channel[1:0])
            2'h0: conv_result = 10'h000;
            2'h1: conv_result = 10'h3FF;
            2'h2: conv_result = 10'h155;
            default: conv_result = 10'h2AA;
        endcase
    end

    // trigger source: low for 4 cycles so the synchroniser surely sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= 0;
        end else if (fire) begin
            low_q <= 4;
        end else if (low_q != 0) begin
            low_q <= low_q - 1;
        end
    end
    assign ext_convert_trigger_n = (low_q == 0); // pulled up when idle

    // interrupt and transfer side: count activations, time the conversion that ends at each transfer request
    // plain always: the counters start from the initial block, which an always_ff may not share
    always @(posedge clk) begin
        if (conv_sample) begin
            samp_cnt <= samp_cnt + 1;
            cyc_q <= 1;
        end else begin
            cyc_q <= cyc_q + 1;
        end
        if (xfer_req) begin
            xfer_cnt <= xfer_cnt + 1;
            conv_len <= cyc_q;
        end
    end
    initial begin
        xfer_cnt = 0;
        samp_cnt = 0;
        cyc_q = 0;
        conv_len = 0;
    end
endmodule

// file: dv/atc_adc_ctrl_test.sv
`timescale 1ns/1ps
module atc_adc_ctrl_test;
    import atc_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} atc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic fire = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_sample;
    logic [3:0] conv_channel;
    logic [9:0] conv_result;
    logic irq;
    logic xfer_req;
    logic trig_n;
    logic [31:0] rd;
    logic err;
    int xfer_cnt, samp_cnt, conv_len, n;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    atc_row_t rows [10] = '{
        '{1'b1, ATC_CR_OFS, 32'h000000FF, 32'h00000000, 1'b0},
        '{1'b0, ATC_CR_OFS, 32'h00000000, 32'h000000CF, 1'b0},
        '{1'b1, ATC_CR_OFS, 32'h0000000C, 32'h00000000, 1'b0},
        '{1'b0, ATC_CR_OFS, 32'h00000000, 32'h0000000F, 1'b0},
        '{1'b0, ATC_MSTOP_OFS, 32'h00000000, 32'h00000000, 1'b0},
        '{1'b0, 8'h30, 32'h00000000, 32'h00000000, 1'b1},
        '{1'b1, ATC_IRQ_MASK_OFS, 32'h00000001, 32'h00000000, 1'b0},
        '{1'b0, ATC_CSR_OFS, 32'h00000000, 32'h00000040, 1'b0},
        '{1'b1, ATC_IRQ_MASK_OFS, 32'h00000000, 32'h00000000, 1'b0},
        '{1'b0, ATC_IRQ_MASK_OFS, 32'h00000000, 32'h00000000, 1'b0}};

    atc_adc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_convert_trigger_n(trig_n), .conv_sample(conv_sample), .conv_channel(conv_channel),
        .conv_result(conv_result), .conversion_end_irq(irq), .xfer_req(xfer_req));
    atc_far_model far_u (.clk(clk), .rst_n(rst_n), .fire(fire), .conv_sample(conv_sample),
        .conv_channel(conv_channel), .xfer_req(xfer_req), .conv_result(conv_result),
        .ext_convert_trigger_n(trig_n), .xfer_cnt(xfer_cnt), .samp_cnt(samp_cnt), .conv_len(conv_len));

    always #50 clk = ~clk;

    // hang guard: the whole run needs well under 5000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk_word(what, exp, rd);
    endtask

    task automatic wait_xfer(input int target);
        n = 0;
        while (xfer_cnt < target && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk_bit("transfer activation", 1'b1, xfer_cnt == target);
    endtask

    task automatic pulse_trigger();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_bit("irq after reset", 1'b0, irq);
        apb(1'b1, ATC_CSR_OFS, 32'h00000020);
        chk_bit("stopped write error", 1'b1, err);
        apb(1'b0, ATC_CSR_OFS, 32'h00000000);
        chk_bit("stopped read error", 1'b1, err);
        repeat (80) @(negedge clk);
        chk_word("samples while stopped", 32'h0, samp_cnt);
        apb(1'b1, ATC_MSTOP_OFS, 32'h00000000);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk_bit("slave error", rows[i].e, err);
            if (!rows[i].w) chk_word("register read", rows[i].x, rd);
        end
        $display("test registers done");

        // single software start, channel 1, enable on
        apb(1'b1, ATC_CSR_OFS, 32'h00000061);
        rd_chk("start held", ATC_CSR_OFS, 32'h00000061);
        wait_xfer(1);
        chk_word("single length", 32'd68, conv_len);
        rd_chk("end status", ATC_CSR_OFS, 32'h000000C1);
        chk_bit("irq raised", 1'b1, irq);
        rd_chk("max code", ATC_DATA_OFS + 8'h04, 32'h000003FF);
        apb(1'b1, ATC_IRQ_STAT_OFS, 32'h00000001);
        chk_bit("irq withdrawn", 1'b0, irq);
        rd_chk("flag cleared", ATC_CSR_OFS, 32'h00000041);
        $display("test single done");

        // trigger ignored with source 01, taken with 11
        apb(1'b1, ATC_CR_OFS, 32'h0000004C);
        apb(1'b1, ATC_CSR_OFS, 32'h00000040);
        pulse_trigger();
        repeat (60) @(negedge clk);
        chk_word("no trigger start", 32'd1, samp_cnt);
        apb(1'b1, ATC_CR_OFS, 32'h000000CC);
        pulse_trigger();
        wait_xfer(2);
        chk_word("trigger length", 32'd68, conv_len);
        rd_chk("trigger end", ATC_CSR_OFS, 32'h000000C0);
        chk_bit("irq on trigger end", 1'b1, irq);
        apb(1'b1, ATC_IRQ_MASK_OFS, 32'h00000000);
        chk_bit("irq masked", 1'b0, irq);
        rd_chk("min code", ATC_DATA_OFS, 32'h00000000);
        apb(1'b1, ATC_IRQ_MASK_OFS, 32'h00000001);
        chk_bit("irq on enable", 1'b1, irq);
        apb(1'b1, ATC_CSR_OFS, 32'h000000C0);
        chk_bit("irq cleared", 1'b0, irq);
        $display("test trigger done");

        // scan of group 0..3, repeats until start is cleared
        apb(1'b1, ATC_CR_OFS, 32'h0000000C);
        apb(1'b1, ATC_CSR_OFS, 32'h00000073);
        wait_xfer(3);
        chk_word("scan length", 32'd64, conv_len);
        rd_chk("scan running", ATC_CSR_OFS, 32'h000000F3);
        rd_chk("scan ch2", ATC_DATA_OFS + 8'h08, 32'h00000155);
        rd_chk("scan ch3", ATC_DATA_OFS + 8'h0C, 32'h000002AA);
        apb(1'b1, ATC_CSR_OFS, 32'h000000F3);
        wait_xfer(4);
        apb(1'b1, ATC_CSR_OFS, 32'h00000080);
        n = samp_cnt;
        repeat (300) @(negedge clk);
        chk_word("scan stopped", n, samp_cnt);
        chk_bit("irq after stop", 1'b0, irq);
        $display("test scan done");

        // single at clock select 10 takes the 134-state length
        apb(1'b1, ATC_CR_OFS, 32'h00000008);
        apb(1'b1, ATC_CSR_OFS, 32'h00000060);
        wait_xfer(5);
        chk_word("slow single length", 32'd134, conv_len);
        apb(1'b1, ATC_CSR_OFS, 32'h000000C0);
        chk_bit("irq cleared again", 1'b0, irq);
        $display("test clock select done");

        // second reset in mid-run returns to module stop
        apb(1'b1, ATC_CSR_OFS, 32'h00000061);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("stop after reset", ATC_MSTOP_OFS, 32'h00000001);
        apb(1'b0, ATC_CSR_OFS, 32'h00000000);
        chk_bit("stopped again", 1'b1, err);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
